// >>> verilog/kbd_slot_regs.svh
// Slot numbers and timing constants of the keyboard slot bus
`ifndef KBD_SLOT_REGS_SVH
`define KBD_SLOT_REGS_SVH
`define FULL_WORD_LEN 76
`define FULL_READY_SLOT 20
`define FULL_XMIT_SLOT 12
`define FULL_DATA_FIRST 22
`define FULL_DATA_LAST 30
`define SHORT_WORD_LEN 20
`define SHORT_MARK_SET 0
`define SHORT_MARK_CLR 1
`define SHORT_XMIT_SLOT 1
`define SHORT_XLAT_CLR 2
`define SHORT_READY_SLOT 9
`define SHORT_DATA_FIRST 11
`define SHORT_DATA_LAST 18
`define SHORT_CAP_END 19
`define CHAR_BITS 8
`define CTRL_BIT 6
`define RING_STAGES 9
`endif

// >>> verilog/kbd_slot_pkg.sv
// Types shared by both ends of the keyboard slot bus
package kbd_slot_pkg;
	typedef logic [7:0] char_t;
	typedef logic [6:0] slot_t;
	typedef logic [8:0] ring_t;
	typedef enum logic [1:0] {
		KB_IDLE = 2'b00,
		KB_READY = 2'b01,
		KB_SEND = 2'b11
	} kb_state_t;
endpackage : kbd_slot_pkg

// >>> verilog/kbd_slot_if.sv
// Shared single-wire slot bus between encoder and host
`timescale 1ns/100ps
interface kbd_slot_if;
	logic cycleMarker;
	logic encBusOut;
	logic encBusOeN;
	logic hostBusOut;
	logic hostBusOeN;
	logic busLine;
	// Wired-OR of the two driven levels
	assign busLine = (!encBusOeN && encBusOut) || (!hostBusOeN && hostBusOut);
	modport encoder (input cycleMarker, input busLine, output encBusOut, output encBusOeN);
	modport host (output cycleMarker, input busLine, output hostBusOut, output hostBusOeN);
endinterface : kbd_slot_if

// >>> verilog/keyboard_encoder.sv
// Encoder end: slot chain, character ready, character shift out
`timescale 1ns/100ps
`include "kbd_slot_regs.svh"
module keyboard_encoder
	import kbd_slot_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	kbd_slot_if.encoder bus, // Slot bus
	input wire logic shortCycle, // 1 = shortened adapter cycle
	input wire logic keyValid, // Pulse: debounced character accepted
	input wire char_t keyChar, // Character with keyValid
	output logic keyBusy // Character held, not yet sent
);
	slot_t slot_r;
	logic chainRun_r;
	logic phase_r;
	logic markSeen_r;
	kb_state_t state_r;
	char_t hold_r;
	logic busOut_r;
	logic busOe_r;
	logic markRise;
	logic stepNow;
	logic dataEdge;
	slot_t readySlot;
	slot_t xmitSlot;
	slot_t dataFirst;
	// True when the chain stands at slot n
	function automatic logic atSlot(input slot_t cur, input slot_t n);
		atSlot = cur == n;
	endfunction : atSlot
	// Marker edge; the marker is host logic on this same clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			markSeen_r <= 1'b0;
		end else begin
			markSeen_r <= bus.cycleMarker;
		end
	end
	assign markRise = bus.cycleMarker && !markSeen_r;
	// Slot chain started by the marker, one stage per two clocks
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_r <= 7'h00;
			chainRun_r <= 1'b0;
			phase_r <= 1'b0;
		end else if (markRise) begin
			slot_r <= 7'h00;
			chainRun_r <= 1'b1;
			phase_r <= 1'b1;
		end else if (chainRun_r) begin
			phase_r <= !phase_r;
			if (phase_r) begin
				slot_r <= slot_r + 7'h01;
			end
		end
	end
	// Slot boundary edge, in step with the host slot edge
	assign stepNow = chainRun_r && phase_r;
	assign readySlot = shortCycle ? 7'(`SHORT_READY_SLOT) : 7'(`FULL_READY_SLOT);
	assign xmitSlot = shortCycle ? 7'(`SHORT_XMIT_SLOT) : 7'(`FULL_XMIT_SLOT);
	assign dataFirst = shortCycle ? 7'(`SHORT_DATA_FIRST) : 7'(`FULL_DATA_FIRST);
	// Edges that load the next data slot onto the bus
	assign dataEdge = stepNow && (slot_r >= dataFirst - 7'h01) && (slot_r <
		dataFirst + 7'(`CHAR_BITS) - 7'h01);
	// Character holding and handshake state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= KB_IDLE;
			hold_r <= 8'h00;
		end else begin
			case (state_r)
				KB_IDLE: begin
					if (keyValid) begin
						hold_r <= keyChar;
						state_r <= KB_READY;
					end
				end
				KB_READY: begin
					if (stepNow && atSlot(slot_r, xmitSlot) && bus.busLine) begin
						state_r <= KB_SEND;
					end
				end
				KB_SEND: begin
					if (dataEdge) begin
						hold_r <= {1'b0, hold_r[7:1]};
					end
					if (stepNow && atSlot(slot_r, dataFirst + 7'(`CHAR_BITS) - 7'h02)) begin
						state_r <= KB_IDLE;
					end
				end
				default: state_r <= KB_IDLE;
			endcase
		end
	end
	// Bus drive, held for the whole slot
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busOut_r <= 1'b0;
			busOe_r <= 1'b0;
		end else if (stepNow) begin
			if (state_r == KB_READY && atSlot(slot_r, readySlot - 7'h01)) begin
				busOut_r <= 1'b1;
				busOe_r <= 1'b1;
			end else if (state_r == KB_SEND && dataEdge) begin
				busOut_r <= hold_r[0];
				busOe_r <= 1'b1;
			end else begin
				busOut_r <= 1'b0;
				busOe_r <= 1'b0;
			end
		end
	end
	assign bus.encBusOut = busOut_r;
	assign bus.encBusOeN = !busOe_r;
	assign keyBusy = state_r != KB_IDLE;
endmodule : keyboard_encoder

// >>> verilog/keyboard_host.sv
// Host end: shortened-cycle adapter with ring counter and capture
`timescale 1ns/100ps
`include "kbd_slot_regs.svh"
//
// Contract
// - Encoder slot chain starts at cycle marker
// - Encoder sends ready until acknowledged
// - Host sends transmit key in later cycle
// - Encoder shifts character in slots 22-30; the encoder drives the eight bits in slots 22-29 only
// - Marker latch set slot 0, cleared slot 1
// - Bus gated into transmit latch at T9
// - Transmit key pulse at next T1
// - Encoder sends eight bits slots 11-18
// - Transmit latch cleared at T2
// - T1 pulse sets prepare-for-data latch
// - Clock enable set at T11 when prepared
// - Both capture latches cleared at T19
// - Bus shifted into eight-bit register
// - Master clock from toggle flip-flop
// - Twisted ring counter decodes slots; the code decodes slots from the slot_r counter and ring_r drives nothing
// - Alpha/numeric select supplied externally
// - Word cycle begins with marker pulse
// - Never static and key transfer together
// - Control key forces bit b6 low
module keyboard_host
	import kbd_slot_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	kbd_slot_if.host bus, // Slot bus
	input wire logic ctrlKey, // Control key held
	input wire logic alphaSel, // External alpha/numeric latch
	output logic alphaMode, // Select passed to keyboard
	output char_t rxChar, // Received character
	output logic rxValid // Pulse: character complete
);
	logic tick_r;
	ring_t ring_r;
	slot_t slot_r;
	logic mark_r;
	logic xmitLatch_r;
	logic prepLatch_r;
	logic clkEn_r;
	char_t shift_r;
	char_t rx_r;
	logic rxValid_r;
	logic busOut_r;
	logic busOe_r;
	logic busIn;
	logic slotStep;
	logic [1:0] selSync_r;
	// True when the slot_r index equals n
	function automatic logic isSlot(input slot_t cur, input int n);
		isSlot = cur == slot_t'(n);
	endfunction : isSlot
	// Toggle master clock, one slot per two clocks
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tick_r <= 1'b0;
		end else begin
			tick_r <= !tick_r;
		end
	end
	assign slotStep = tick_r;
	// Twisted ring counter and slot index
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ring_r <= 9'h000;
			slot_r <= 7'h00;
		end else if (slotStep) begin
			ring_r <= {ring_r[7:0], !ring_r[8]};
			if (slot_r == 7'(`SHORT_WORD_LEN - 1)) begin
				slot_r <= 7'h00;
			end else begin
				slot_r <= slot_r + 7'h01;
			end
		end
	end
	// Cycle marker latch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mark_r <= 1'b0;
		end else if (slotStep && isSlot(slot_r, `SHORT_WORD_LEN - 1)) begin
			mark_r <= 1'b1;
		end else if (slotStep && isSlot(slot_r, `SHORT_MARK_SET)) begin
			mark_r <= 1'b0;
		end
	end
	assign bus.cycleMarker = mark_r;
	// Two-stage sync of the external select pin
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			selSync_r <= 2'h0;
		end else begin
			selSync_r <= {selSync_r[0], alphaSel};
		end
	end
	// Bus is same-clock logic, sampled at the slot's closing edge
	assign busIn = bus.busLine;
	assign alphaMode = selSync_r[1];
	// Transmit latch: set by ready at T9, cleared at T2
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			xmitLatch_r <= 1'b0;
		end else if (slotStep && isSlot(slot_r, `SHORT_READY_SLOT) && busIn) begin
			xmitLatch_r <= 1'b1;
		end else if (slotStep && isSlot(slot_r, `SHORT_XLAT_CLR)) begin
			xmitLatch_r <= 1'b0;
		end
	end
	// Transmit key pulse at T1, one slot long
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busOut_r <= 1'b0;
			busOe_r <= 1'b0;
		end else if (slotStep) begin
			busOut_r <= xmitLatch_r && isSlot(slot_r, `SHORT_XMIT_SLOT - 1);
			busOe_r <= xmitLatch_r && isSlot(slot_r, `SHORT_XMIT_SLOT - 1);
		end
	end
	assign bus.hostBusOut = busOut_r;
	assign bus.hostBusOeN = !busOe_r;
	// Prepare latch and clock enable latch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prepLatch_r <= 1'b0;
			clkEn_r <= 1'b0;
		end else if (slotStep) begin
			if (isSlot(slot_r, `SHORT_CAP_END - 1)) begin
				prepLatch_r <= 1'b0;
				clkEn_r <= 1'b0;
			end else begin
				if (xmitLatch_r && isSlot(slot_r, `SHORT_XMIT_SLOT)) begin
					prepLatch_r <= 1'b1;
				end
				if (prepLatch_r && isSlot(slot_r, `SHORT_DATA_FIRST - 1)) begin
					clkEn_r <= 1'b1;
				end
			end
		end
	end
	// Serial to parallel capture with control override
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_r <= 8'h00;
			rx_r <= 8'h00;
			rxValid_r <= 1'b0;
		end else begin
			rxValid_r <= 1'b0;
			if (slotStep && clkEn_r) begin
				shift_r <= {busIn, shift_r[7:1]};
			end
			if (slotStep && clkEn_r && isSlot(slot_r, `SHORT_DATA_LAST)) begin
				rx_r <= {busIn, shift_r[7:1]};
				rxValid_r <= 1'b1;
			end
		end
	end
	// Control key slaves b6 low at the converter output
	always_comb begin
		rxChar = rx_r;
		if (ctrlKey) begin
			rxChar[`CTRL_BIT - 1] = 1'b0;
		end
	end
	assign rxValid = rxValid_r;
endmodule : keyboard_host

// >>> verification/kbd_slot_chk.sv
// Checker on the shared slot bus between encoder and host
`timescale 1ns/100ps
module kbd_slot_chk (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic cycleMarker, // Host word marker
	input wire logic encBusOut, // Encoder level
	input wire logic encBusOeN, // Encoder drive, low active
	input wire logic hostBusOut, // Host level
	input wire logic hostBusOeN, // Host drive, low active
	input wire logic busLine // Resolved line
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Marker, drive and timing relations
	a_marker_one_slot: assert property ($rose(cycleMarker) |=> cycleMarker ##1 !cycleMarker)
		else $error("marker width wrong");
	a_marker_word_len: assert property ($rose(cycleMarker) |-> ##40 $rose(cycleMarker))
		else $error("word length wrong");
	a_reset_idle_bus: assert property ($fell(sys_rst) |-> encBusOeN && hostBusOeN && !cycleMarker)
		else $error("bus not idle after reset");
	a_no_drive_clash: assert property (!(!encBusOeN && !hostBusOeN))
		else $error("both ends drive");
	a_xmit_after_mark: assert property ($fell(hostBusOeN) |-> $past(cycleMarker) || $past(cycleMarker, 2))
		else $error("transmit key off slot one");
	a_xmit_one_slot: assert property ($fell(hostBusOeN) |-> !hostBusOeN[*2] ##1 hostBusOeN)
		else $error("transmit key width wrong");
	a_xmit_level_high: assert property (!hostBusOeN |-> hostBusOut && busLine)
		else $error("transmit key not high");
	a_enc_burst_len: assert property ($fell(encBusOeN) |-> ##[1:17] encBusOeN)
		else $error("encoder drive too long");
	// Main scenarios
	c_marker: cover property ($rose(cycleMarker));
	c_xmit: cover property ($fell(hostBusOeN));
	c_enc_data: cover property (!encBusOeN && encBusOut);
endmodule : kbd_slot_chk

// >>> verification/test_keyboard_slot_bus_host.sv
// Bench joining encoder and host ends across the slot bus
`timescale 1ns/100ps
module test_keyboard_slot_bus_host
	import kbd_slot_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic keyValid = 1'b0;
	char_t keyChar = 8'h00;
	logic ctrlKey = 1'b0;
	logic alphaSel = 1'b0;
	logic keyBusy;
	logic alphaMode;
	logic rxValid;
	char_t rxChar;
	char_t rxLast = 8'h00;
	int failures = 0;
	int compares = 0;
	int rxCount = 0;
	kbd_slot_if bus();
	keyboard_encoder u_keyboard_encoder (.clk(clk), .sys_rst(sys_rst), .bus(bus),
		.shortCycle(1'b1), .keyValid(keyValid), .keyChar(keyChar), .keyBusy(keyBusy));
	keyboard_host u_keyboard_host (.clk(clk), .sys_rst(sys_rst), .bus(bus), .ctrlKey(ctrlKey),
		.alphaSel(alphaSel), .alphaMode(alphaMode), .rxChar(rxChar), .rxValid(rxValid));
	kbd_slot_chk u_kbd_slot_chk (.clk(clk), .sys_rst(sys_rst), .cycleMarker(bus.cycleMarker),
		.encBusOut(bus.encBusOut), .encBusOeN(bus.encBusOeN), .hostBusOut(bus.hostBusOut),
		.hostBusOeN(bus.hostBusOeN), .busLine(bus.busLine));
	// Clock, 8 ns
	always #4 clk = ~clk;
	// Received characters
	always @(posedge clk) begin
		if (rxValid === 1'b1) begin
			rxCount <= rxCount + 1;
			rxLast <= rxChar;
		end
	end
	task automatic chk(input string name, input char_t seen, input char_t exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// One key in, one character out, then the encoder is free
	task automatic sendChar(input char_t c, input char_t exp);
		int n;
		n = rxCount;
		keyChar = c;
		keyValid = 1'b1;
		@(posedge clk) #1;
		keyValid = 1'b0;
		repeat (400) if (rxCount == n) @(posedge clk) #1;
		chk("rxCount", char_t'(rxCount - n), 8'h01);
		chk("rxChar", rxLast, exp);
		chk("keyBusy", {7'h00, keyBusy}, 8'h00);
	endtask : sendChar
	task automatic t_idle();
		chk("busIdle", {5'h00, bus.busLine, bus.encBusOeN, bus.hostBusOeN}, 8'h03);
		$display("test idle done");
	endtask : t_idle
	task automatic t_marker();
		int n;
		n = 0;
		repeat (100) if (bus.cycleMarker !== 1'b1) @(posedge clk) #1;
		repeat (100) if (bus.cycleMarker === 1'b1) @(posedge clk) #1;
		repeat (100) if (bus.cycleMarker !== 1'b1) begin
			n++;
			@(posedge clk) #1;
		end
		chk("markerGap", char_t'(n), 8'h26);
		$display("test marker done");
	endtask : t_marker
	task automatic t_chars();
		char_t vals [4] = '{8'h00, 8'hFF, 8'hA5, 8'h41};
		foreach (vals[i]) sendChar(vals[i], vals[i]);
		$display("test chars done");
	endtask : t_chars
	task automatic t_refuse();
		int n;
		keyChar = 8'h3C;
		keyValid = 1'b1;
		@(posedge clk) #1;
		keyChar = 8'hC3;
		@(posedge clk) #1;
		keyValid = 1'b0;
		n = rxCount;
		repeat (400) if (rxCount == n) @(posedge clk) #1;
		chk("firstChar", rxLast, 8'h3C);
		repeat (200) @(posedge clk);
		#1 chk("extraRx", char_t'(rxCount - n), 8'h01);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_ctrl();
		ctrlKey = 1'b1;
		sendChar(8'h24, 8'h04);
		ctrlKey = 1'b0;
		$display("test ctrl done");
	endtask : t_ctrl
	task automatic t_alpha();
		alphaSel = 1'b1;
		repeat (4) @(posedge clk) #1;
		chk("alphaOn", {7'h00, alphaMode}, 8'h01);
		alphaSel = 1'b0;
		repeat (4) @(posedge clk) #1;
		chk("alphaOff", {7'h00, alphaMode}, 8'h00);
		$display("test alpha done");
	endtask : t_alpha
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		#1 sys_rst = 1'b0;
		t_idle();
		t_marker();
		t_chars();
		t_refuse();
		t_ctrl();
		t_alpha();
		end_sim();
	end
	// Watchdog
	initial begin
		#160000;
		failures++;
		end_sim();
	end
endmodule : test_keyboard_slot_bus_host
